// ===== verilog/drive_status_pkg.sv
package drive_status_pkg;

  // ----------------------------------------------------------------
  // Status block and reply delay word addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_DOUT_STATE  = 16'h2211;
  localparam logic [15:0] ADDR_STEP_INDEX  = 16'h2212;
  localparam logic [15:0] ADDR_DIN_PINS    = 16'h2213;
  localparam logic [15:0] ADDR_DOUT_PINS   = 16'h2214;
  localparam logic [15:0] ADDR_ENC_REVS    = 16'h2215;
  localparam logic [15:0] ADDR_PULSE_RATE  = 16'h2216;
  localparam logic [15:0] ADDR_PULSE_POS   = 16'h2217;
  localparam logic [15:0] ADDR_TRACK_ERR   = 16'h2218;
  localparam logic [15:0] ADDR_OVERLOAD    = 16'h2219;
  localparam logic [15:0] ADDR_GROUND_LEAK = 16'h221a;
  localparam logic [15:0] ADDR_RIPPLE      = 16'h221b;
  localparam logic [15:0] ADDR_PLC_MIRROR  = 16'h221c;
  localparam logic [15:0] ADDR_POLES       = 16'h221d;
  localparam logic [15:0] ADDR_USER_PAGE   = 16'h221e;
  localparam logic [15:0] ADDR_DISPLAY_OUT = 16'h221f;
  localparam logic [15:0] ADDR_TURNS       = 16'h2220;
  localparam logic [15:0] ADDR_RUN_POS     = 16'h2221;
  localparam logic [15:0] ADDR_FAN_SPEED   = 16'h2222;
  localparam logic [15:0] ADDR_CTRL_MODE   = 16'h2223;
  localparam logic [15:0] ADDR_CARRIER     = 16'h2224;
  localparam logic [15:0] ADDR_RESERVED    = 16'h2225;
  localparam logic [15:0] ADDR_DRIVE_STATE = 16'h2226;
  localparam logic [15:0] ADDR_EST_TORQUE  = 16'h2227;
  localparam logic [15:0] ADDR_TORQUE_CMD  = 16'h2228;
  localparam logic [15:0] ADDR_ENERGY      = 16'h2229;
  localparam logic [15:0] ADDR_PCOUNT_LO   = 16'h222a;
  localparam logic [15:0] ADDR_PCOUNT_HI   = 16'h222b;
  localparam logic [15:0] ADDR_MPOS_LO     = 16'h222c;
  localparam logic [15:0] ADDR_MPOS_HI     = 16'h222d;
  localparam logic [15:0] ADDR_PID_REF     = 16'h222e;
  localparam logic [15:0] ADDR_PID_OFFSET  = 16'h222f;
  localparam logic [15:0] ADDR_PID_OUT     = 16'h2230;
  localparam logic [15:0] ADDR_HW_ID       = 16'h2231;
  localparam logic [15:0] ADDR_AUX_FREQ    = 16'h2232;
  localparam logic [15:0] ADDR_MASTER_FREQ = 16'h2233;
  localparam logic [15:0] ADDR_COMB_FREQ   = 16'h2234;
  localparam logic [15:0] ADDR_DELAY       = 16'h0927;

  // ----------------------------------------------------------------
  // Function and exception codes, limits
  // ----------------------------------------------------------------
  localparam logic [7:0]  FN_READ     = 8'h03;
  localparam logic [7:0]  FN_WRITE    = 8'h06;
  localparam logic [7:0]  EXC_FLAG    = 8'h80;
  localparam logic [7:0]  EXC_NONE    = 8'h00;
  localparam logic [7:0]  EXC_FUNC    = 8'h01;
  localparam logic [7:0]  EXC_ADDR    = 8'h02;
  localparam logic [7:0]  EXC_DATA    = 8'h03;
  localparam logic [7:0]  EXC_EXEC    = 8'h04;
  localparam logic [7:0]  ASCII_ZERO  = 8'h30;
  localparam logic [15:0] DELAY_RST   = 16'h0014;
  localparam logic [15:0] DELAY_MAX   = 16'h07d0;
  localparam logic [15:0] MAX_WORDS   = 16'h007d;
  localparam logic [15:0] CNT_MAX     = 16'hffff;

  // ----------------------------------------------------------------
  // Timing: one delay step of 0.1 ms
  // ----------------------------------------------------------------
  localparam int TICK_NS  = 100000;
  localparam int CLK_NS   = 100;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_SEND = 2'b11
  } rsp_state_e;

endpackage : drive_status_pkg

// ===== verilog/drive_status_map.sv
// Function
// [R01] Exception reply sets bit seven of function
// [R02] Code 1 bad function, 2 bad address
// [R03] Code 3 bad data, 4 execution failure
// [R04] Display warning shows exception code, two characters
// [R05] Programmable reply delay, 0.1 ms steps
// [R06] Status bits 1:0 give rotation direction
// [R07] Status bits 3:2 give ready or error
// [R08] Bit 4 output active, bit 5 alarm
// [R09] Mode register: 0 speed, 1 torque
// [R10] Revolution count restarts on reversal, saturates
// [R11] Pulse position accumulates, saturates at maximum
// [R12] Turn count holds stopped, clears at run
// [R13] Run position holds stopped, clears at run
// [R14] Input pulse count: low word first
// [R15] Motor position: low word first
// [R16] Combined frequency is master plus/minus auxiliary
// [R17] Reserved status addresses read as zero
`timescale 1ns/1ps
module drive_status_map
  import drive_status_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  req_func,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_count,
  input  wire logic [15:0] req_wdata,
  output logic             rsp_start,
  output logic [7:0]       rsp_func,
  output logic [7:0]       rsp_exc,
  output logic             rsp_word_valid,
  output logic [15:0]      rsp_word,
  output logic             rsp_word_last,
  output logic             warn_active,
  output logic [15:0]      warn_text,
  input  wire logic [15:0] dout_state,
  input  wire logic [15:0] step_index,
  input  wire logic [15:0] din_pins,
  input  wire logic [15:0] dout_pins,
  input  wire logic [15:0] pulse_rate,
  input  wire logic [15:0] track_error,
  input  wire logic [15:0] overload_times,
  input  wire logic [15:0] ground_leak_level,
  input  wire logic [15:0] bus_ripple,
  input  wire logic [15:0] plc_mirror,
  input  wire logic [15:0] motor_poles,
  input  wire logic [15:0] user_page,
  input  wire logic [15:0] display_out,
  input  wire logic [15:0] fan_speed,
  input  wire logic [15:0] carrier_freq,
  input  wire logic [15:0] est_torque,
  input  wire logic [15:0] torque_cmd,
  input  wire logic [15:0] energy_total,
  input  wire logic [31:0] pulse_count,
  input  wire logic [31:0] motor_pos,
  input  wire logic [15:0] pid_ref,
  input  wire logic [15:0] pid_offset,
  input  wire logic [15:0] pid_out,
  input  wire logic [15:0] hw_id,
  input  wire logic [15:0] aux_freq,
  input  wire logic [15:0] master_freq,
  input  wire logic        aux_subtract,
  input  wire logic        dir_fwd,
  input  wire logic        dir_rev,
  input  wire logic        drive_ready,
  input  wire logic        drive_fault,
  input  wire logic        output_on,
  input  wire logic        alarm,
  input  wire logic        torque_mode,
  input  wire logic        enc_rev_pulse,
  input  wire logic        stop_disp_zero,
  input  wire logic        pulse_pos_step,
  input  wire logic        running,
  input  wire logic        turn_pulse,
  input  wire logic        run_pos_step
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rsp_state_e  state_ff;
  logic [7:0]  func_ff;
  logic [7:0]  exc_ff;
  logic [7:0]  nxt_exc;
  logic [15:0] addr_ff;
  logic [15:0] left_ff;
  logic [15:0] delay_set_ff;
  logic [15:0] dly_left_ff;
  logic [15:0] tick_ff;
  logic [15:0] enc_cnt_ff;
  logic [15:0] pulse_pos_ff;
  logic [15:0] turns_ff;
  logic [15:0] run_pos_ff;
  logic        dir_rev_ff;
  logic        running_ff;
  logic [15:0] rd_word_c;
  logic [15:0] status_word;
  logic [15:0] comb_freq;
  logic [15:0] last_addr;
  logic        accept;
  logic        enc_clear;
  logic        run_start;
  logic        wait_done;

  // Status address test, used for the first and last word of a read
  function automatic logic in_block(input logic [15:0] a);
    in_block = (a >= ADDR_DOUT_STATE) && (a <= ADDR_COMB_FREQ);
  endfunction : in_block
  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // One request at a time; a new one waits until the reply is out
  assign req_ready = (state_ff == ST_IDLE);
  assign accept    = req_valid && req_ready;
  assign last_addr = 16'(req_addr + req_count - 16'h0001);

  // Exception classification, data faults before address faults
  always_comb begin
    nxt_exc = EXC_NONE;
    if (req_func == FN_READ) begin
      if (req_count == 16'h0000 || req_count > MAX_WORDS) begin
        nxt_exc = EXC_DATA;                                  // see [R03]
      end else if (req_addr == ADDR_DELAY) begin
        nxt_exc = (req_count == 16'h0001) ? EXC_NONE : EXC_ADDR;
      end else if (!in_block(req_addr) || !in_block(last_addr)) begin
        nxt_exc = EXC_ADDR;                                  // see [R02]
      end
    end else if (req_func == FN_WRITE) begin
      if (req_addr == ADDR_DELAY) begin
        nxt_exc = (req_wdata > DELAY_MAX) ? EXC_DATA : EXC_NONE; // see [R03]
      end else if (in_block(req_addr)) begin
        nxt_exc = EXC_EXEC;                                  // see [R03]
      end else begin
        nxt_exc = EXC_ADDR;                                  // see [R02]
      end
    end else begin
      nxt_exc = EXC_FUNC;                                    // see [R02]
    end
  end
  // ----------------------------------------------------------------
  // Response delay setting
  // ----------------------------------------------------------------
  // Written only by a valid single write; out-of-range writes are refused
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      delay_set_ff <= DELAY_RST;
    end else if (accept && req_func == FN_WRITE && req_addr == ADDR_DELAY
                 && nxt_exc == EXC_NONE) begin
      delay_set_ff <= req_wdata;                             // see [R05]
    end
  end
  // ----------------------------------------------------------------
  // Reply sequencer
  // ----------------------------------------------------------------
  assign wait_done = (state_ff == ST_WAIT) && (dly_left_ff == 16'h0000);

  // Request capture; the delay in force before the write is used
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      func_ff <= 8'h00;
      exc_ff  <= EXC_NONE;
    end else if (accept) begin
      func_ff <= req_func;
      exc_ff  <= nxt_exc;
    end
  end

  // State walk: idle, wait the delay, send header and words
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (accept) begin
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (wait_done) begin
            state_ff <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (exc_ff != EXC_NONE || left_ff == 16'h0000) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Delay count in 0.1 ms steps, each TICK_CYCLES clocks long
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dly_left_ff <= 16'h0000;
      tick_ff     <= 16'h0000;
    end else if (accept) begin
      dly_left_ff <= delay_set_ff;                           // see [R05]
      tick_ff     <= 16'h0000;
    end else if (state_ff == ST_WAIT && dly_left_ff != 16'h0000) begin
      if (tick_ff == 16'(TICK_CYCLES - 1)) begin
        tick_ff     <= 16'h0000;
        dly_left_ff <= dly_left_ff - 16'h0001;               // see [R05]
      end else begin
        tick_ff <= tick_ff + 16'h0001;
      end
    end
  end

  // Word pointer; writes reply with the header only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_ff <= 16'h0000;
      left_ff <= 16'h0000;
    end else if (accept) begin
      addr_ff <= req_addr;
      left_ff <= (req_func == FN_READ) ? req_count : 16'h0000;
    end else if (state_ff == ST_SEND && exc_ff == EXC_NONE
                 && left_ff != 16'h0000) begin
      addr_ff <= addr_ff + 16'h0001;
      left_ff <= left_ff - 16'h0001;
    end
  end

  // Header pulse; exception replies carry the flagged function
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_start <= 1'b0;
      rsp_func  <= 8'h00;
      rsp_exc   <= EXC_NONE;
    end else begin
      rsp_start <= wait_done;
      if (wait_done) begin
        rsp_func <= (exc_ff != EXC_NONE) ? (func_ff | EXC_FLAG) : func_ff; // see [R01]
        rsp_exc  <= exc_ff;                                  // see [R01]
      end
    end
  end

  // Word stream, one register per clock after the header
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_word_valid <= 1'b0;
      rsp_word       <= 16'h0000;
      rsp_word_last  <= 1'b0;
    end else begin
      rsp_word_valid <= 1'b0;
      rsp_word_last  <= 1'b0;
      if (state_ff == ST_SEND && exc_ff == EXC_NONE && left_ff != 16'h0000) begin
        rsp_word_valid <= 1'b1;
        rsp_word       <= rd_word_c;
        rsp_word_last  <= (left_ff == 16'h0001);
      end
    end
  end
  // ----------------------------------------------------------------
  // Local warning display
  // ----------------------------------------------------------------
  // Stays up until a request is served cleanly
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      warn_active <= 1'b0;
      warn_text   <= {ASCII_ZERO, ASCII_ZERO};
    end else if (wait_done) begin
      warn_active <= (exc_ff != EXC_NONE);                   // see [R04]
      if (exc_ff != EXC_NONE) begin
        warn_text <= {ASCII_ZERO + {4'h0, exc_ff[7:4]},
                      ASCII_ZERO + {4'h0, exc_ff[3:0]}};     // see [R04]
      end
    end
  end

  // ----------------------------------------------------------------
  // Derived status values
  // ----------------------------------------------------------------
  // Fault wins over ready so an error is never hidden
  assign status_word = {10'h000, alarm, output_on,                  // see [R08]
                        drive_fault ? 2'b10 : (drive_ready ? 2'b01 : 2'b00), // see [R07]
                        dir_fwd ? 2'b01 : (dir_rev ? 2'b10 : 2'b00)};        // see [R06]

  // Combined frequency wraps in 16 bits like the source values
  assign comb_freq = aux_subtract ? 16'(master_freq - aux_freq)
                                  : 16'(master_freq + aux_freq);   // see [R16]

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  assign enc_clear = (dir_rev != dir_rev_ff) || (!running && stop_disp_zero);
  assign run_start = running && !running_ff;

  // Previous direction and run level for edge detection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dir_rev_ff <= 1'b0;
      running_ff <= 1'b0;
    end else begin
      dir_rev_ff <= dir_rev;
      running_ff <= running;
    end
  end

  // Revolution count: restart wins over a pulse in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enc_cnt_ff <= 16'h0000;
    end else if (enc_clear) begin
      enc_cnt_ff <= 16'h0000;                                // see [R10]
    end else if (enc_rev_pulse && enc_cnt_ff != CNT_MAX) begin
      enc_cnt_ff <= enc_cnt_ff + 16'h0001;                   // see [R10]
    end
  end

  // Pulse position, held at the top once reached
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_pos_ff <= 16'h0000;
    end else if (pulse_pos_step && pulse_pos_ff != CNT_MAX) begin
      pulse_pos_ff <= pulse_pos_ff + 16'h0001;               // see [R11]
    end
  end

  // Turns and run position: cleared at run start, frozen while stopped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      turns_ff   <= 16'h0000;
      run_pos_ff <= 16'h0000;
    end else if (run_start) begin
      turns_ff   <= 16'h0000;                                // see [R12]
      run_pos_ff <= 16'h0000;                                // see [R13]
    end else if (running) begin
      turns_ff   <= turns_ff + {15'h0000, turn_pulse};       // see [R12]
      run_pos_ff <= run_pos_ff + {15'h0000, run_pos_step};   // see [R13]
    end
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (addr_ff)
      ADDR_DOUT_STATE:  rd_word_c = dout_state;
      ADDR_STEP_INDEX:  rd_word_c = step_index;
      ADDR_DIN_PINS:    rd_word_c = din_pins;
      ADDR_DOUT_PINS:   rd_word_c = dout_pins;
      ADDR_ENC_REVS:    rd_word_c = enc_cnt_ff;
      ADDR_PULSE_RATE:  rd_word_c = pulse_rate;
      ADDR_PULSE_POS:   rd_word_c = pulse_pos_ff;
      ADDR_TRACK_ERR:   rd_word_c = track_error;
      ADDR_OVERLOAD:    rd_word_c = overload_times;
      ADDR_GROUND_LEAK: rd_word_c = ground_leak_level;
      ADDR_RIPPLE:      rd_word_c = bus_ripple;
      ADDR_PLC_MIRROR:  rd_word_c = plc_mirror;
      ADDR_POLES:       rd_word_c = motor_poles;
      ADDR_USER_PAGE:   rd_word_c = user_page;
      ADDR_DISPLAY_OUT: rd_word_c = display_out;
      ADDR_TURNS:       rd_word_c = turns_ff;
      ADDR_RUN_POS:     rd_word_c = run_pos_ff;
      ADDR_FAN_SPEED:   rd_word_c = fan_speed;
      ADDR_CTRL_MODE:   rd_word_c = {15'h0000, torque_mode};  // see [R09]
      ADDR_CARRIER:     rd_word_c = carrier_freq;
      ADDR_RESERVED:    rd_word_c = 16'h0000;                 // see [R17]
      ADDR_DRIVE_STATE: rd_word_c = status_word;
      ADDR_EST_TORQUE:  rd_word_c = est_torque;
      ADDR_TORQUE_CMD:  rd_word_c = torque_cmd;
      ADDR_ENERGY:      rd_word_c = energy_total;
      ADDR_PCOUNT_LO:   rd_word_c = pulse_count[15:0];        // see [R14]
      ADDR_PCOUNT_HI:   rd_word_c = pulse_count[31:16];       // see [R14]
      ADDR_MPOS_LO:     rd_word_c = motor_pos[15:0];          // see [R15]
      ADDR_MPOS_HI:     rd_word_c = motor_pos[31:16];         // see [R15]
      ADDR_PID_REF:     rd_word_c = pid_ref;
      ADDR_PID_OFFSET:  rd_word_c = pid_offset;
      ADDR_PID_OUT:     rd_word_c = pid_out;
      ADDR_HW_ID:       rd_word_c = hw_id;
      ADDR_AUX_FREQ:    rd_word_c = aux_freq;
      ADDR_MASTER_FREQ: rd_word_c = master_freq;
      ADDR_COMB_FREQ:   rd_word_c = comb_freq;
      ADDR_DELAY:       rd_word_c = delay_set_ff;
      default:          rd_word_c = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_exc_func_flag: assert property (@(posedge clk) disable iff (!rst_n) // see [R01]
    rsp_start && rsp_exc != EXC_NONE |-> rsp_func[7] && !rsp_word_valid)
    else $error("exception reply without flagged function");

  chk_bad_func_code: assert property (@(posedge clk) disable iff (!rst_n) // see [R02]
    accept && req_func != FN_READ && req_func != FN_WRITE
    |=> exc_ff == EXC_FUNC)
    else $error("unknown function not given code 1");

  chk_bad_addr_code: assert property (@(posedge clk) disable iff (!rst_n) // see [R02]
    accept && req_func == FN_READ && req_count == 16'h0001
    && req_addr != ADDR_DELAY && !in_block(req_addr) |=> exc_ff == EXC_ADDR)
    else $error("unknown address not given code 2");

  chk_bad_data_code: assert property (@(posedge clk) disable iff (!rst_n) // see [R03]
    accept && req_func == FN_WRITE && req_addr == ADDR_DELAY
    && req_wdata > DELAY_MAX |=> exc_ff == EXC_DATA && $stable(delay_set_ff))
    else $error("bad delay value not refused with code 3");

  chk_warn_text_code: assert property (@(posedge clk) disable iff (!rst_n) // see [R04]
    rsp_start && rsp_exc != EXC_NONE |->
    warn_active && warn_text == {ASCII_ZERO, ASCII_ZERO + rsp_exc})
    else $error("warning text does not match exception");

  chk_zero_delay_reply: assert property (@(posedge clk) disable iff (!rst_n) // see [R05]
    accept && delay_set_ff == 16'h0000 |-> !rsp_start ##2 rsp_start)
    else $error("zero delay reply not two cycles after accept");

  chk_status_dir_bits: assert property (@(posedge clk) disable iff (!rst_n) // see [R06]
    dir_rev && !dir_fwd |-> status_word[1:0] == 2'b10)
    else $error("reverse direction bits wrong");

  chk_status_err_bits: assert property (@(posedge clk) disable iff (!rst_n) // see [R07]
    drive_fault |-> status_word[3:2] == 2'b10 && status_word[5] == alarm)
    else $error("error or alarm bits wrong");

  chk_rev_count_sat: assert property (@(posedge clk) disable iff (!rst_n) // see [R10]
    enc_cnt_ff == CNT_MAX && !enc_clear |=> enc_cnt_ff == CNT_MAX)
    else $error("revolution count left saturation");

  chk_turns_run_clr: assert property (@(posedge clk) disable iff (!rst_n) // see [R12]
    run_start |=> turns_ff == 16'h0000 && run_pos_ff == 16'h0000)
    else $error("run counters not cleared at run start");

  chk_turns_hold_stop: assert property (@(posedge clk) disable iff (!rst_n) // see [R13]
    !running && !run_start |=> $stable(turns_ff) && $stable(run_pos_ff))
    else $error("run counters moved while stopped");

endmodule : drive_status_map

// ===== tb/modbus_master_model.sv
`timescale 1ns/1ps
module modbus_master_model (
  input  wire logic        clk,
  output logic             req_valid,
  input  wire logic        req_ready,
  output logic [7:0]       req_func,
  output logic [15:0]      req_addr,
  output logic [15:0]      req_count,
  output logic [15:0]      req_wdata,
  input  wire logic        rsp_start,
  input  wire logic        rsp_word_valid,
  input  wire logic        rsp_word_last,
  input  wire logic [15:0] rsp_word
);
  logic [15:0] words [$];
  int          lat, lastn;
  bit          hung;

  // Idle lines at time zero
  initial begin
    {req_valid, req_func, req_addr, req_count, req_wdata} = '0;
  end

  // One request; lines flip once released so stale data never looks valid
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, n, d);
    int k;
    words = {};
    lastn = 0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (req_ready !== 1'b1 && k < 100);
    {req_valid, req_func, req_addr, req_count, req_wdata} = {1'b1, f, a, n, d};
    @(posedge clk);
    @(negedge clk);
    {req_valid, req_func, req_addr, req_count, req_wdata} = {1'b0, ~f, ~a, ~n, ~d};
    lat = 1;
    do begin
      @(posedge clk);
      #1;
      lat++;
    end while (rsp_start !== 1'b1 && lat < 10000);
    hung = k >= 100 || lat >= 10000;
    repeat (n + 2) begin
      @(posedge clk);
      #1;
      if (rsp_word_valid === 1'b1) words.push_back(rsp_word);
      if (rsp_word_last === 1'b1) lastn = words.size();
    end
  endtask : xfer
endmodule : modbus_master_model

// ===== tb/drive_status_map_modbus_slave_test.sv
`timescale 1ns/1ps
module drive_status_map_modbus_slave_test;
  import drive_status_pkg::*;
  localparam int TK = 2;
  logic clk, rst_n, req_valid, req_ready, rsp_start, rsp_word_valid, rsp_word_last, warn_active;
  logic aux_subtract, dir_fwd, dir_rev, drive_ready, drive_fault, output_on, alarm, torque_mode;
  logic enc_rev_pulse, stop_disp_zero, pulse_pos_step, running, turn_pulse, run_pos_step;
  logic [7:0]  req_func, rsp_func, rsp_exc;
  logic [15:0] req_addr, req_count, req_wdata, rsp_word, warn_text, s, enc, ppos, turns, rpos;
  int          miscompares, compares, dl;
  // ----------------------------------------------------------------
  // Status values follow s, offset by their word index
  // ----------------------------------------------------------------
  wire [15:0] dout_state = s + 16'h01, step_index = s + 16'h02, din_pins = s + 16'h03;
  wire [15:0] dout_pins = s + 16'h04, pulse_rate = s + 16'h06, track_error = s + 16'h08;
  wire [15:0] overload_times = s + 16'h09, ground_leak_level = s + 16'h0a;
  wire [15:0] bus_ripple = s + 16'h0b, plc_mirror = s + 16'h0c, motor_poles = s + 16'h0d;
  wire [15:0] user_page = s + 16'h0e, display_out = s + 16'h0f, fan_speed = s + 16'h12;
  wire [15:0] carrier_freq = s + 16'h14, est_torque = s + 16'h17, torque_cmd = s + 16'h18;
  wire [15:0] energy_total = s + 16'h19, pid_ref = s + 16'h1e, pid_offset = s + 16'h1f;
  wire [15:0] pid_out = s + 16'h20, hw_id = s + 16'h21, aux_freq = s + 16'h22;
  wire [15:0] master_freq = s + 16'h23;
  wire [31:0] pulse_count = {s + 16'h1b, s + 16'h1a}, motor_pos = {s + 16'h1d, s + 16'h1c};

  drive_status_map #(.TICK_CYCLES(TK)) dut_u (.*);
  modbus_master_model m_u (.*);

  // Free-running 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Expected word at one status address
  function automatic logic [15:0] ex(input logic [15:0] a);
    case (a)
      16'h2215: return enc;
      16'h2217: return ppos;
      16'h2220: return turns;
      16'h2221: return rpos;
      16'h2223: return {15'h0, torque_mode};
      16'h2225: return 16'h0;
      16'h2226: return {10'h0, alarm, output_on, drive_fault ? 2'b10 : {1'b0, drive_ready},
                        dir_fwd ? 2'b01 : {dir_rev, 1'b0}};
      16'h2234: return aux_subtract ? 16'h1 : 16'(s * 2 + 16'h45);
      default:  return 16'(s + a - 16'h2210);
    endcase
  endfunction : ex

  task automatic ck(input string nm, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : ck

  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  // One transfer; latency follows the delay setting in force
  task automatic go(input logic [7:0] f, input logic [15:0] a, n, d);
    logic [15:0] le;
    le = 16'(2 + dl * TK);
    m_u.xfer(f, a, n, d);
    if (m_u.hung) begin
      miscompares++;
      $display("FAIL handshake expected done seen hang");
      wrap_up();
    end
    ck("latency", le, 16'(m_u.lat));
    if (f == FN_WRITE && a == ADDR_DELAY && d <= DELAY_MAX) dl = d;
  endtask : go

  task automatic pls(ref logic p, input int n);
    @(negedge clk);
    p = 1'b1;
    repeat (n) @(negedge clk);
    p = 1'b0;
  endtask : pls

  // Whole status block in one read
  task automatic rd_all();
    go(FN_READ, 16'h2211, 16'd36, 16'h0);
    ck("exc", 16'h0, {8'h0, rsp_exc});
    ck("words", 16'd36, 16'(m_u.words.size()));
    ck("last", 16'd36, 16'(m_u.lastn));
    for (int i = 0; i < m_u.words.size(); i++) begin
      ck("word", ex(16'(16'h2211 + i)), m_u.words[i]);
    end
  endtask : rd_all

  task automatic t_delay();
    go(FN_WRITE, ADDR_DELAY, 16'h1, DELAY_MAX);
    go(FN_WRITE, ADDR_DELAY, 16'h1, 16'h0);
    go(FN_READ, ADDR_DELAY, 16'h1, 16'h0);
    ck("delay", 16'h0, m_u.words[0]);
    go(FN_WRITE, ADDR_DELAY, 16'h1, 16'h3);
    go(FN_READ, ADDR_DELAY, 16'h1, 16'h0);
    ck("delay", 16'h3, m_u.words[0]);
    $display("done t_delay");
  endtask : t_delay

  task automatic t_map();
    @(negedge clk);
    s = 16'h1000;
    {aux_subtract, dir_fwd, dir_rev, drive_ready, drive_fault, output_on, alarm, torque_mode} = 8'h50;
    rd_all();
    @(negedge clk);
    s = 16'h7ff0;
    {aux_subtract, dir_fwd, dir_rev, drive_ready, drive_fault, output_on, alarm, torque_mode} = 8'hbf;
    rd_all();
    $display("done t_map");
  endtask : t_map

  task automatic t_cnt();
    pls(enc_rev_pulse, 3);
    pls(pulse_pos_step, 2);
    pls(running, 1);
    @(negedge clk);
    running = 1'b1;
    pls(turn_pulse, 4);
    pls(run_pos_step, 2);
    running = 1'b0;
    {enc, ppos, turns, rpos} = {16'h3, 16'h2, 16'h4, 16'h2};
    rd_all();
    dir_rev = 1'b0;
    pls(enc_rev_pulse, 2);
    pls(stop_disp_zero, 1);
    pls(running, 1);
    {enc, turns, rpos} = '0;
    rd_all();
    $display("done t_cnt");
  endtask : t_cnt

  task automatic t_exc();
    logic [7:0]  f [5] = '{8'h10, FN_READ, FN_READ, FN_WRITE, FN_WRITE};
    logic [15:0] a [5] = '{16'h2211, 16'h2211, 16'h2210, 16'h2211, ADDR_DELAY};
    logic [15:0] d [5] = '{16'h0, 16'h0, 16'h0, 16'h5, 16'h07d1};
    logic [7:0]  x [5] = '{EXC_FUNC, EXC_DATA, EXC_ADDR, EXC_EXEC, EXC_DATA};
    for (int i = 0; i < 5; i++) begin
      go(f[i], a[i], (i == 1) ? 16'h0 : 16'h1, d[i]);
      ck("func", {8'h0, f[i] | EXC_FLAG}, {8'h0, rsp_func});
      ck("code", {8'h0, x[i]}, {8'h0, rsp_exc});
      ck("nwords", 16'h0, 16'(m_u.words.size()));
      ck("warn", {ASCII_ZERO, 8'(ASCII_ZERO + x[i])}, warn_active ? warn_text : 16'h0);
    end
    rd_all();
    ck("warn", 16'h0, {15'h0, warn_active});
    $display("done t_exc");
  endtask : t_exc

  // Reset for 20 cycles, then the scenarios in turn
  initial begin
    {s, enc, ppos, turns, rpos, miscompares, compares} = '0;
    {aux_subtract, dir_fwd, dir_rev, drive_ready, drive_fault, output_on, alarm} = '0;
    {torque_mode, enc_rev_pulse, stop_disp_zero, pulse_pos_step, running} = '0;
    {turn_pulse, run_pos_step} = '0;
    dl = DELAY_RST;
    rst_n = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_delay();
    t_map();
    t_cnt();
    t_exc();
    wrap_up();
  end
endmodule : drive_status_map_modbus_slave_test
